// File: core/tssc_regs.v
// Purpose: register bank, conversion sequencer and alarm pins of a temperature sensor
// Assumes: serial port is mode 3, command byte then 8 or 16 data bits, msb first
// Notes: sample_i is the converter result on clock_i, taken when a conversion ends
// Behaviour
// R01 - status, temperature, identification are read-only
// R02 - status 0x80, setup 0x00 at reset
// R03 - limit and hysteresis registers reset values
// R04 - limit flags clear on read or recovery
// R05 - low flag set below low limit
// R06 - high flag set above high limit
// R07 - critical flag set above critical limit
// R08 - ready bit low on result, high on temperature read
// R09 - mode write re-arms ready in timed modes
// R10 - fault queue bits set faults needed
// R11 - setup bit 2 sets critical pin polarity
// R12 - setup bit 3 sets limit pin polarity
// R13 - setup bit 4 picks comparator or interrupt
// R14 - mode 00 converts back to back
// R15 - mode 01 converts once then shuts down
// R16 - mode 10 converts once per second
// R17 - mode 11 shuts down, port stays alive
// R18 - setup bit 7 selects 13 or 16 bits
// R19 - fault count only over consecutive conversions
// R20 - interrupt mode: any read releases pins
// R21 - 16-bit mode: low bits carry result
// R22 - flags evaluated once after each result
`timescale 1ns/1ps
`include "tssc_defs.vh"
module tssc_regs #(
  parameter ONESHOT_CYC = `TSSC_ONESHOT_MS * (`TSSC_CLK_HZ / 1000),
  parameter SPS_CONV_CYC = `TSSC_SPS_CONV_MS * (`TSSC_CLK_HZ / 1000),
  parameter SPS_PERIOD_CYC = `TSSC_SPS_PERIOD_MS * (`TSSC_CLK_HZ / 1000),
  parameter CONT_CONV_CYC = `TSSC_CONT_CONV_MS * (`TSSC_CLK_HZ / 1000),
  parameter CNT_W = 27,
  parameter [7:0] ID_VALUE = `TSSC_ID_DEFAULT
) (
  input wire clock_i,
  input wire arst_n_i,
  input wire spi_sclk_i,
  input wire spi_cs_n_i,
  input wire spi_mosi_i,
  output wire spi_miso_o,
  output wire spi_miso_oe_o,
  input wire [15:0] sample_i,
  output wire sensor_on_o,
  output wire conv_done_o,
  output wire critical_alarm_pin_o,
  output wire limit_alarm_pin_o
);
  localparam [1:0] ST_OFF = 2'h0;
  localparam [1:0] ST_CONV = 2'h1;
  localparam [1:0] ST_IDLE = 2'h2;
  localparam [CNT_W-1:0] ONESHOT_LAST = ONESHOT_CYC[CNT_W-1:0] - 1'b1;
  localparam [CNT_W-1:0] SPS_CONV_LAST = SPS_CONV_CYC[CNT_W-1:0] - 1'b1;
  localparam [CNT_W-1:0] SPS_IDLE_LAST = SPS_PERIOD_CYC[CNT_W-1:0] - SPS_CONV_CYC[CNT_W-1:0] - 1'b1;
  localparam [CNT_W-1:0] CONT_LAST = CONT_CONV_CYC[CNT_W-1:0] - 1'b1;

  // ************************************************************
  // serial port sampling
  // ************************************************************
  wire [2:0] pins_s;
  wire sclk_s;
  wire cs_n_s;
  wire mosi_s;
  reg sclk_prev_q;
  wire sclk_rise;
  wire sclk_fall;
  wire frame_on;

  tssc_sync #(
    .W(3),
    .RST(3'h6)
  ) u_pin_sync (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .async_i({spi_sclk_i, spi_cs_n_i, spi_mosi_i}),
    .sync_o(pins_s)
  );

  assign sclk_s = pins_s[2];
  assign cs_n_s = pins_s[1];
  assign mosi_s = pins_s[0];
  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~sclk_s & sclk_prev_q;
  assign frame_on = ~cs_n_s;

  // ************************************************************
  // register state
  // ************************************************************
  reg [7:0] setup_q;
  reg [15:0] crit_q;
  reg [7:0] hyst_q;
  reg [15:0] high_q;
  reg [15:0] low_q;
  reg [15:0] temp_q;
  reg rdy_q;
  wire flag_low;
  wire flag_high;
  wire flag_crit;

  wire res16 = setup_q[`TSSC_CFG_RES];
  wire [1:0] op_mode = setup_q[`TSSC_CFG_OM_HI:`TSSC_CFG_OM_LO];

  // ************************************************************
  // frame decode
  // ************************************************************
  reg [4:0] bit_cnt_q;
  reg [6:0] cmd_q;
  reg [15:0] rx_q;
  reg [15:0] tx_q;
  reg is_rd_q;
  reg [2:0] addr_q;
  reg miso_q;
  reg miso_oe_q;
  wire [7:0] cmd_byte = {cmd_q, mosi_s};
  wire cmd_done = frame_on & sclk_rise & (bit_cnt_q == 5'd7);
  wire cmd_rd = cmd_byte[`TSSC_CMD_RD];
  wire [2:0] cmd_addr = cmd_byte[`TSSC_CMD_A_HI:`TSSC_CMD_A_LO];
  wire rd_evt = cmd_done & cmd_rd;
  wire wide_addr = (addr_q == `TSSC_ADDR_TEMP) | (addr_q == `TSSC_ADDR_CRIT) |
                   (addr_q == `TSSC_ADDR_HIGH) | (addr_q == `TSSC_ADDR_LOW);
  wire [4:0] last_bit = wide_addr ? 5'd23 : 5'd15;
  wire wr_evt = frame_on & sclk_rise & ~is_rd_q & (bit_cnt_q == last_bit);
  wire [15:0] wr_data = {rx_q[14:0], mosi_s};
  wire setup_wr = wr_evt & (addr_q == `TSSC_ADDR_SETUP);
  wire rd_flags = rd_evt & (cmd_addr == `TSSC_ADDR_FLAGS);
  wire rd_temp = rd_evt & (cmd_addr == `TSSC_ADDR_TEMP);
  reg [15:0] rd_val;

  // 8-bit registers sit in the upper byte so they shift out first
  always @* begin
    rd_val = 16'h0000;
    case (cmd_addr)
      `TSSC_ADDR_FLAGS: rd_val = {rdy_q, flag_crit, flag_high, flag_low, 4'h0, 8'h00};
      `TSSC_ADDR_SETUP: rd_val = {setup_q, 8'h00};
      `TSSC_ADDR_TEMP: rd_val = res16 ? temp_q :
                                {temp_q[15:3], flag_crit, flag_high, flag_low}; // [R21] [R18]
      `TSSC_ADDR_IDENT: rd_val = {ID_VALUE, 8'h00};
      `TSSC_ADDR_CRIT: rd_val = crit_q;
      `TSSC_ADDR_HYST: rd_val = {hyst_q, 8'h00};
      `TSSC_ADDR_HIGH: rd_val = high_q;
      `TSSC_ADDR_LOW: rd_val = low_q;
      default: rd_val = 16'h0000;
    endcase
  end

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sclk_prev_q <= 1'b1;
      bit_cnt_q <= 5'h00;
      cmd_q <= 7'h00;
      rx_q <= 16'h0000;
      tx_q <= 16'h0000;
      is_rd_q <= 1'b0;
      addr_q <= 3'h0;
      miso_q <= 1'b0;
      miso_oe_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      miso_oe_q <= frame_on;
      if (!frame_on) begin
        bit_cnt_q <= 5'h00;
        is_rd_q <= 1'b0;
      end else begin
        if (sclk_rise) begin
          if (bit_cnt_q != 5'h1f) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
          end
          if (bit_cnt_q < 5'd8) begin
            cmd_q <= cmd_byte[6:0];
          end else begin
            rx_q <= wr_data;
          end
          if (cmd_done) begin
            is_rd_q <= cmd_rd;
            addr_q <= cmd_addr;
            tx_q <= rd_val;
          end
        end
        if (sclk_fall && is_rd_q && (bit_cnt_q >= 5'd8)) begin
          miso_q <= tx_q[15];
          tx_q <= {tx_q[14:0], 1'b0};
        end
      end
    end
  end

  // ************************************************************
  // writable registers
  // ************************************************************
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      setup_q <= `TSSC_RST_SETUP; // [R02]
      crit_q <= `TSSC_RST_CRIT; // [R03]
      hyst_q <= `TSSC_RST_HYST; // [R03]
      high_q <= `TSSC_RST_HIGH; // [R03]
      low_q <= `TSSC_RST_LOW; // [R03]
    end else if (wr_evt) begin
      // flags, temperature and identification have no write path
      case (addr_q) // [R01]
        `TSSC_ADDR_SETUP: setup_q <= wr_data[7:0];
        `TSSC_ADDR_CRIT: crit_q <= wr_data;
        `TSSC_ADDR_HYST: hyst_q <= wr_data[7:0];
        `TSSC_ADDR_HIGH: high_q <= wr_data;
        `TSSC_ADDR_LOW: low_q <= wr_data;
        default: crit_q <= crit_q;
      endcase
    end
  end

  // ************************************************************
  // conversion sequencer
  // ************************************************************
  reg [1:0] state_q;
  reg [CNT_W-1:0] cnt_q;
  reg restart_q;
  reg done_q;
  reg eval_q;
  reg sensor_on_q;
  reg [CNT_W-1:0] conv_last;

  always @* begin
    case (op_mode)
      `TSSC_OM_ONESHOT: conv_last = ONESHOT_LAST; // [R15]
      `TSSC_OM_SPS: conv_last = SPS_CONV_LAST; // [R16]
      default: conv_last = CONT_LAST;
    endcase
  end

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ST_CONV;
      cnt_q <= {CNT_W{1'b0}};
      restart_q <= 1'b0;
      done_q <= 1'b0;
      sensor_on_q <= 1'b0;
    end else begin
      restart_q <= setup_wr;
      done_q <= 1'b0;
      sensor_on_q <= (state_q == ST_CONV);
      if (restart_q) begin
        // any write to the setup register restarts the sequence in the new mode
        cnt_q <= {CNT_W{1'b0}};
        state_q <= (op_mode == `TSSC_OM_OFF) ? ST_OFF : ST_CONV; // [R17]
      end else begin
        case (state_q)
          ST_CONV: begin
            if (cnt_q >= conv_last) begin
              done_q <= 1'b1;
              cnt_q <= {CNT_W{1'b0}};
              case (op_mode)
                `TSSC_OM_CONT: state_q <= ST_CONV; // [R14]
                `TSSC_OM_SPS: state_q <= ST_IDLE; // [R16]
                default: state_q <= ST_OFF; // [R15]
              endcase
            end else begin
              cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
            end
          end
          ST_IDLE: begin
            if (cnt_q >= SPS_IDLE_LAST) begin
              cnt_q <= {CNT_W{1'b0}};
              state_q <= ST_CONV; // [R16]
            end else begin
              cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
            end
          end
          ST_OFF: cnt_q <= {CNT_W{1'b0}}; // [R17]
          default: state_q <= ST_OFF;
        endcase
      end
    end
  end

  // ************************************************************
  // result capture and ready bit
  // ************************************************************
  wire mode_rearm = setup_wr & ((wr_data[6:5] == `TSSC_OM_ONESHOT) |
                                (wr_data[6:5] == `TSSC_OM_SPS));

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      temp_q <= `TSSC_RST_TEMP;
      rdy_q <= 1'b1; // [R02]
      eval_q <= 1'b0;
    end else begin
      eval_q <= done_q; // [R22]
      if (done_q) begin
        temp_q <= res16 ? sample_i : {sample_i[15:3], 3'h0}; // [R18]
        rdy_q <= 1'b0; // [R08]
      end else if (rd_temp || mode_rearm) begin
        rdy_q <= 1'b1; // [R08] [R09]
      end
    end
  end

  // ************************************************************
  // limit comparison
  // ************************************************************
  // hysteresis is whole degrees, 128 counts each in the 16-bit word
  wire signed [16:0] t_s = {temp_q[15], temp_q};
  wire signed [16:0] hyst_s = {6'h00, hyst_q[3:0], 7'h00};
  wire signed [16:0] low_s = {low_q[15], low_q};
  wire signed [16:0] high_s = {high_q[15], high_q};
  wire signed [16:0] crit_s = {crit_q[15], crit_q};
  wire signed [16:0] low_up = low_s + hyst_s;
  wire signed [16:0] high_dn = high_s - hyst_s;
  wire signed [16:0] crit_dn = crit_s - hyst_s;
  wire below_low = t_s < low_s;
  wire above_high = t_s > high_s;
  wire above_crit = t_s > crit_s;
  wire low_back = t_s > low_up;
  wire high_back = t_s < high_dn;
  wire crit_back = t_s < crit_dn;

  tssc_flag u_flag_low (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .set_i(eval_q & below_low), // [R05]
    .hw_clr_i(eval_q & low_back), // [R04]
    .rd_clr_i(rd_flags), // [R04]
    .flag_o(flag_low)
  );

  tssc_flag u_flag_high (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .set_i(eval_q & above_high), // [R06]
    .hw_clr_i(eval_q & high_back), // [R04]
    .rd_clr_i(rd_flags), // [R04]
    .flag_o(flag_high)
  );

  tssc_flag u_flag_crit (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .set_i(eval_q & above_crit), // [R07]
    .hw_clr_i(eval_q & crit_back), // [R04]
    .rd_clr_i(rd_flags), // [R04]
    .flag_o(flag_crit)
  );

  // ************************************************************
  // fault queue and alarm pins
  // ************************************************************
  reg [2:0] fault_cnt_q;
  reg lim_act_q;
  reg crit_act_q;
  reg crit_pin_q;
  reg lim_pin_q;
  wire fault = below_low | above_high | above_crit;
  wire [2:0] fault_need = {1'b0, setup_q[`TSSC_CFG_FQ_HI:`TSSC_CFG_FQ_LO]};
  wire trip = eval_q & fault & (fault_cnt_q >= fault_need); // [R10]
  wire cmp_mode = setup_q[`TSSC_CFG_CMP];
  wire lim_evt = trip & (below_low | above_high);
  wire crit_evt = trip & above_crit;
  // comparator mode releases only once the reading is back inside the band
  wire lim_rel = cmp_mode ? (eval_q & low_back & high_back) : rd_evt; // [R13] [R20]
  wire crit_rel = cmp_mode ? (eval_q & crit_back) : rd_evt; // [R13] [R20]

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fault_cnt_q <= 3'h0;
      lim_act_q <= 1'b0;
      crit_act_q <= 1'b0;
      crit_pin_q <= 1'b1;
      lim_pin_q <= 1'b1;
    end else begin
      if (eval_q) begin
        if (!fault) begin
          fault_cnt_q <= 3'h0; // [R19]
        end else if (fault_cnt_q != 3'h4) begin
          fault_cnt_q <= fault_cnt_q + 3'h1; // [R19]
        end
      end
      if (lim_evt) begin
        lim_act_q <= 1'b1;
      end else if (lim_rel) begin
        lim_act_q <= 1'b0;
      end
      if (crit_evt) begin
        crit_act_q <= 1'b1;
      end else if (crit_rel) begin
        crit_act_q <= 1'b0;
      end
      crit_pin_q <= setup_q[`TSSC_CFG_CPOL] ? crit_act_q : ~crit_act_q; // [R11]
      lim_pin_q <= setup_q[`TSSC_CFG_LPOL] ? lim_act_q : ~lim_act_q; // [R12]
    end
  end

  assign spi_miso_o = miso_q;
  assign spi_miso_oe_o = miso_oe_q;
  assign sensor_on_o = sensor_on_q;
  assign conv_done_o = eval_q;
  assign critical_alarm_pin_o = crit_pin_q;
  assign limit_alarm_pin_o = lim_pin_q;
endmodule // tssc_regs

// File: core/tssc_defs.vh
// Purpose: shared constants of the temperature sensor register bank
// Assumes: included by its bare name from the design files
// Notes: definitions only
`ifndef TSSC_DEFS_VH
`define TSSC_DEFS_VH

// ************************************************************
// register addresses
// ************************************************************
`define TSSC_ADDR_FLAGS 3'h0
`define TSSC_ADDR_SETUP 3'h1
`define TSSC_ADDR_TEMP 3'h2
`define TSSC_ADDR_IDENT 3'h3
`define TSSC_ADDR_CRIT 3'h4
`define TSSC_ADDR_HYST 3'h5
`define TSSC_ADDR_HIGH 3'h6
`define TSSC_ADDR_LOW 3'h7

// ************************************************************
// power-on values
// ************************************************************
`define TSSC_RST_FLAGS 8'h80
`define TSSC_RST_SETUP 8'h00
`define TSSC_RST_TEMP 16'h0000
`define TSSC_RST_CRIT 16'h4980
`define TSSC_RST_HYST 8'h05
`define TSSC_RST_HIGH 16'h2000
`define TSSC_RST_LOW 16'h0500
// arbitrary neutral identification value
`define TSSC_ID_DEFAULT 8'h5a

// ************************************************************
// field positions
// ************************************************************
`define TSSC_FLG_LOW 4
`define TSSC_FLG_HIGH 5
`define TSSC_FLG_CRIT 6
`define TSSC_FLG_RDY 7
`define TSSC_CFG_FQ_HI 1
`define TSSC_CFG_FQ_LO 0
`define TSSC_CFG_CPOL 2
`define TSSC_CFG_LPOL 3
`define TSSC_CFG_CMP 4
`define TSSC_CFG_OM_HI 6
`define TSSC_CFG_OM_LO 5
`define TSSC_CFG_RES 7
`define TSSC_CMD_RD 6
`define TSSC_CMD_A_HI 5
`define TSSC_CMD_A_LO 3

// ************************************************************
// operation modes
// ************************************************************
`define TSSC_OM_CONT 2'h0
`define TSSC_OM_ONESHOT 2'h1
`define TSSC_OM_SPS 2'h2
`define TSSC_OM_OFF 2'h3

// ************************************************************
// timing
// ************************************************************
`define TSSC_CLK_HZ 50000000
`define TSSC_ONESHOT_MS 240
`define TSSC_SPS_CONV_MS 60
`define TSSC_SPS_PERIOD_MS 1000
`define TSSC_CONT_CONV_MS 240

`endif

// File: core/tssc_sync.v
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs are asynchronous to clock_i
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module tssc_sync #(
  parameter W = 1,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input wire clock_i,
  input wire arst_n_i,
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_q <= RST;
      sync_q <= RST;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule // tssc_sync

// File: core/tssc_flag.v
// Purpose: one sticky limit flag of the status register
// Assumes: all inputs are single-cycle pulses on clock_i
// Notes: a set arriving with a clear wins so no event is lost
`timescale 1ns/1ps
module tssc_flag (
  input wire clock_i,
  input wire arst_n_i,
  input wire set_i,
  input wire hw_clr_i,
  input wire rd_clr_i,
  output wire flag_o
);
  reg flag_q;

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flag_q <= 1'b0;
    end else if (set_i) begin
      flag_q <= 1'b1;
    end else if (hw_clr_i || rd_clr_i) begin
      flag_q <= 1'b0;
    end
  end

  assign flag_o = flag_q;
endmodule // tssc_flag

// File: bench/tssc_regs_props.sv
// Purpose: port-level assertions for the temperature sensor register bank
// Assumes: sees only the top module ports, one clock domain
// Notes: pin changes are allowed only shortly after a conversion end, or during or shortly after a frame
`timescale 1ns/1ps
module tssc_regs_props (
  input wire clock_i,
  input wire arst_n_i,
  input wire spi_sclk_i,
  input wire spi_cs_n_i,
  input wire spi_mosi_i,
  input wire spi_miso_o,
  input wire spi_miso_oe_o,
  input wire [15:0] sample_i,
  input wire sensor_on_o,
  input wire conv_done_o,
  input wire critical_alarm_pin_o,
  input wire limit_alarm_pin_o
);
  // ************************************************************
  // history of causes
  // ************************************************************
  logic [3:0] done_hist_q;
  logic [7:0] sel_hist_q;
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      done_hist_q <= 4'h0;
      sel_hist_q <= 8'h00;
    end else begin
      done_hist_q <= {done_hist_q[2:0], conv_done_o};
      sel_hist_q <= {sel_hist_q[6:0], ~spi_cs_n_i};
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // sync stages plus the output register take three cycles
  sequence frame_open;
    !spi_cs_n_i [*5];
  endsequence
  sequence frame_closed;
    spi_cs_n_i [*5];
  endsequence
  oe_select_a: assert property (frame_open |-> spi_miso_oe_o)
    else $error("miso enable low inside frame");
  oe_release_a: assert property (frame_closed |-> !spi_miso_oe_o)
    else $error("miso enable high outside frame");
  done_single_a: assert property (conv_done_o |=> !conv_done_o)
    else $error("conversion end longer than one cycle");
  done_in_conv_a: assert property ($rose(conv_done_o) |-> $past(sensor_on_o, 2))
    else $error("conversion end without running conversion");
  on_after_rst_a: assert property ($rose(arst_n_i) |=> sensor_on_o)
    else $error("no conversion after reset");
  pins_idle_a: assert property ($rose(arst_n_i) |-> critical_alarm_pin_o && limit_alarm_pin_o)
    else $error("alarm pins active after reset");
  crit_cause_a: assert property ($changed(critical_alarm_pin_o) |->
    (|done_hist_q) || (|sel_hist_q)) else $error("critical pin moved without cause");
  limit_cause_a: assert property ($changed(limit_alarm_pin_o) |->
    (|done_hist_q) || (|sel_hist_q)) else $error("limit pin moved without cause");
endmodule // tssc_regs_props

bind tssc_regs tssc_regs_props tssc_regs_props_inst (.clock_i(clock_i), .arst_n_i(arst_n_i),
  .spi_sclk_i(spi_sclk_i), .spi_cs_n_i(spi_cs_n_i), .spi_mosi_i(spi_mosi_i),
  .spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o), .sample_i(sample_i),
  .sensor_on_o(sensor_on_o), .conv_done_o(conv_done_o),
  .critical_alarm_pin_o(critical_alarm_pin_o), .limit_alarm_pin_o(limit_alarm_pin_o));

// File: bench/tssc_host_model.sv
// Purpose: serial host that reads and writes the sensor registers
// Assumes: mode 3 frames, four system clocks per serial clock phase
// Notes: mosi is inverted outside frames so no stale bit is mistaken for data
`timescale 1ns/1ps
module tssc_host_model (
  input wire clock_i,
  output logic spi_sclk_o,
  output logic spi_cs_n_o,
  output logic spi_mosi_o,
  input wire spi_miso_i
);
  initial begin
    spi_sclk_o = 1'b1;
    spi_cs_n_o = 1'b1;
    spi_mosi_o = 1'b0;
  end
  task automatic half();
    repeat (4) @(posedge clock_i);
    #1;
  endtask
  // ************************************************************
  // one access per frame, msb first
  // ************************************************************
  task automatic xfer(input logic [7:0] cmd, input int nbits, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [23:0] sh;
    sh = {cmd, wd << (16 - nbits)};
    rd = 16'h0000;
    @(posedge clock_i);
    #1;
    spi_cs_n_o = 1'b0;
    half();
    for (int i = 0; i < 8 + nbits; i++) begin
      spi_sclk_o = 1'b0;
      spi_mosi_o = sh[23 - i];
      half();
      if (i >= 8) rd = {rd[14:0], spi_miso_i};
      spi_sclk_o = 1'b1;
      half();
    end
    spi_cs_n_o = 1'b1;
    spi_mosi_o = ~spi_mosi_o;
    repeat (6) @(posedge clock_i);
  endtask
endmodule // tssc_host_model

// File: bench/testbench.sv
// Purpose: self-checking bench of the temperature sensor register bank
// Assumes: shortened conversion times, host model drives the serial port
// Notes: limits are rewritten early, later expectations use the new values
`timescale 1ns/1ps
module testbench;
  localparam int CONT = 2000;
  localparam int SPS_P = 600;
  localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary value
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [15:0] sample_i = 16'h1000;
  logic [15:0] rd;
  wire sclk, cs_n, mosi, miso, miso_oe, sensor_on, conv_done, crit, limit;
  int err_total = 0;
  int check_count = 0;
  always #10 clock_i = ~clock_i;
  tssc_regs #(.ONESHOT_CYC(300), .SPS_CONV_CYC(100), .SPS_PERIOD_CYC(SPS_P),
    .CONT_CONV_CYC(CONT), .CNT_W(27), .ID_VALUE(ID_VAL)) tssc_regs_inst (.clock_i(clock_i),
    .arst_n_i(arst_n_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
    .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .sample_i(sample_i), .sensor_on_o(sensor_on),
    .conv_done_o(conv_done), .critical_alarm_pin_o(crit), .limit_alarm_pin_o(limit));
  tssc_host_model tssc_host_model_inst (.clock_i(clock_i), .spi_sclk_o(sclk),
    .spi_cs_n_o(cs_n), .spi_mosi_o(mosi), .spi_miso_i(miso));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic int wid(input logic [2:0] a);
    return (a == 3'h2 || a == 3'h4 || a >= 3'h6) ? 16 : 8;
  endfunction
  task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
    tssc_host_model_inst.xfer({2'b01, a, 3'h0}, wid(a), 16'h0000, d);
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    logic [15:0] dummy;
    tssc_host_model_inst.xfer({2'b00, a, 3'h0}, wid(a), d, dummy);
  endtask
  // waits for a conversion end, then lets the alarm pins settle
  task automatic wait_done(input int lim, output int n);
    n = 0;
    while (conv_done !== 1'b1 && n < lim) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    if (n >= lim) begin
      err_total++;
      $display("unexpected at %0t: no conversion end", $time);
    end
    repeat (4) @(posedge clock_i);
    #1;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic test_reset();
    logic [15:0] exp [8];
    exp = '{16'h0080, 16'h0000, 16'h0000, {8'h00, ID_VAL}, 16'h4980, 16'h0005, 16'h2000,
      16'h0500};
    for (int a = 0; a < 8; a++) begin
      rd_reg(a[2:0], rd);
      check(rd, exp[a]);
    end
    $display("test_reset done");
  endtask
  task automatic test_access();
    logic [15:0] wv [8];
    wv = '{16'h0080, 16'h0060, 16'h0000, {8'h00, ID_VAL}, 16'h4900, 16'h0005, 16'h1f00,
      16'h0600};
    wr_reg(3'h1, 16'h0060);
    for (int a = 0; a < 8; a++) begin
      if (a != 1) wr_reg(a[2:0], (a == 4 || a >= 6) ? wv[a] : 16'h00ff);
      if (a == 5) wr_reg(3'h5, 16'h0005);
    end
    for (int a = 0; a < 8; a++) begin
      rd_reg(a[2:0], rd);
      check(rd, wv[a]);
    end
    check(16'(sensor_on), 16'h0000);
    $display("test_access done");
  endtask
  task automatic test_oneshot();
    int n;
    sample_i = 16'h4a00;
    wr_reg(3'h1, 16'h0020);
    wait_done(1000, n);
    check({14'h0, crit, limit}, 16'h0000);
    rd_reg(3'h0, rd);
    check(rd, 16'h0060);
    check({14'h0, crit, limit}, 16'h0003);
    rd_reg(3'h0, rd);
    check(rd, 16'h0000);
    check(16'(sensor_on), 16'h0000);
    wr_reg(3'h1, 16'h0020);
    rd_reg(3'h0, rd);
    check(rd, 16'h0080);
    wait_done(1000, n);
    rd_reg(3'h2, rd);
    check(rd & 16'hfff8, 16'h4a00);
    rd_reg(3'h0, rd);
    check(rd, 16'h00e0);
    $display("test_oneshot done");
  endtask
  task automatic test_sps_low();
    int n;
    sample_i = 16'h0123;
    wr_reg(3'h1, 16'h00dc);
    wait_done(1000, n);
    check({14'h0, crit, limit}, 16'h0001);
    rd_reg(3'h0, rd);
    check(rd, 16'h0010);
    rd_reg(3'h2, rd);
    check(rd, 16'h0123);
    check(16'(limit), 16'h0001);
    sample_i = 16'h0900;
    wait_done(SPS_P + 100, n);
    check(16'(n > 150), 16'h0001);
    check(16'(limit), 16'h0000);
    $display("test_sps_low done");
  endtask
  task automatic test_fault_queue();
    logic [6:0] pat;
    int n;
    pat = 7'b1111011;
    wr_reg(3'h1, 16'h0003);
    for (int i = 0; i < 7; i++) begin
      sample_i = pat[i] ? 16'h4a00 : 16'h1000;
      wait_done(CONT + 100, n);
      check({14'h0, crit, limit}, (i == 6) ? 16'h0000 : 16'h0003);
    end
    $display("test_fault_queue done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock_i);
    #1;
    arst_n_i = 1'b1;
    repeat (4) @(posedge clock_i);
    test_reset();
    test_access();
    test_oneshot();
    test_sps_low();
    test_fault_queue();
    stop_test();
  end
  // about two and a half times the expected run length
  initial begin
    #1000000;
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule // testbench
